// ---- rtl/adcs_pkg.sv ----
// Purpose: Shared constants and types of the converter sequencer and its register file.
// Assumes: Registers are 8 bits wide, one per aligned 32-bit word of an AXI4-Lite slave.
// Notes:   Register positions are word indices; the byte address is four times the index.
package adcs_pkg;

    // Register word indices.
    localparam logic [7:0] IDX_CLOCK_DIVIDER = 8'hf2;
    localparam logic [7:0] IDX_CONTROL       = 8'hf3;
    localparam logic [7:0] IDX_RESULT_LOW    = 8'hf4;
    localparam logic [7:0] IDX_RESULT_HIGH   = 8'hf5;
    localparam logic [7:0] IDX_PIN_ASSIGN    = 8'hf6;
    localparam logic [7:0] IDX_IRQ_STATUS    = 8'hf8;
    localparam logic [7:0] IDX_IRQ_ENABLE    = 8'hf9;
    localparam logic [7:0] IDX_IRQ_CLEAR     = 8'hfa;

    // Control, clock divider and interrupt register fields.
    localparam int CTRL_QUIET_BIT  = 6;
    localparam int CTRL_ENABLE_BIT = 5;
    localparam int CTRL_DONE_BIT   = 4;
    localparam int CTRL_START_BIT  = 3;
    localparam int CTRL_CHAN_MSB   = 2;
    localparam int DIV_VALUE_MSB   = 4;
    localparam int IRQ_DONE_BIT    = 0;

    // Reset values.
    localparam logic [7:0] RST_CLOCK_DIVIDER = 8'h00;
    localparam logic [7:0] RST_CONTROL       = 8'h00;
    localparam logic [7:0] RST_PIN_ASSIGN    = 8'h00;
    localparam logic [9:0] RST_RESULT        = 10'h000;

    // Timing counts, in converter clock periods and system clock cycles.
    localparam logic [3:0] CONV_PERIODS   = 4'hb;
    localparam logic [6:0] DIV_ZERO_CYCLE = 7'h40;
    localparam int         SINGLE_MULT    = 4;
    localparam int         DOUBLE_MULT    = 2;

    // Bus answers.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b01,
        CV_BUSY = 2'b10
    } adcs_conv_state_type;

endpackage : adcs_pkg

// ---- rtl/adcs_sequencer.sv ----
// Purpose: Register file and conversion sequencer of an 8-channel 10-bit converter.
// Assumes: core_result is driven by the converter core on clk_sys and is settled on the
//          last converter clock period of a conversion.
// Notes:   The whole state is one packed struct, registered in a single process.
// Function
// R1: Each pin-assign bit set routes its port pin to the analog input.
// R2: Quiet mode bit holds the processor idle during a conversion.
// R3: Control bit 5 enables the converter; clear means standby.
// R4: Hardware sets the done flag on a result; only software clears it.
// R5: The done flag is the source of the converter interrupt request.
// R6: Writing start launches one conversion; hardware clears start when done.
// R7: Three-bit channel field picks the input of the next conversion.
// R8: Reserved bits read as zero; software writes of them are ignored.
// R9: Single speed: converter clock is system clock over four times divider.
// R10: Double speed: converter clock is system clock over two times divider.
// R11: High result register shows result bits 9 to 2.
// R12: Low result register shows result bits 1 and 0.
// R13: Interrupt request only while done flag and interrupt enable are set.
// R14: Channel code is a plain binary input index 0 to 7.
// R15: Divider value zero gives system clock over 64.
// R16: A conversion lasts 11 converter clock periods, first one sample-and-hold.
// R17: Start is ignored while busy, in standby, or on an unassigned channel.
// R18: Both result registers and the done flag update in the same cycle.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module adcs_sequencer
    import adcs_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              double_speed_clocking,
    input  wire logic [9:0]        core_result,
    output logic [7:0]             analog_pin_enable,
    output logic [2:0]             channel_select,
    output logic                   converter_enable,
    output logic                   sample_hold,
    output logic                   converter_clock_tick,
    output logic                   conversion_busy,
    output logic                   cpu_idle_request,
    output logic                   adc_irq
);

    typedef struct packed {
        adcs_conv_state_type state;
        logic [6:0]          div_cnt;
        logic [3:0]          period_cnt;
        logic                tick;
        logic                sample;
        logic                idle_req;
        logic [7:0]          pin_assign;
        logic                quiet;
        logic                enable;
        logic                done_flag;
        logic                start;
        logic [2:0]          chan;
        logic [2:0]          chan_conv;
        logic [4:0]          div_value;
        logic [9:0]          result;
        logic                irq_en;
        logic                irq;
        logic                aw_have;
        logic                w_have;
        logic [7:0]          w_idx;
        logic [7:0]          w_data;
        logic                w_lane0;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic [7:0]          gap_cnt;
        logic [3:0]          ticks_seen;
    } adcs_state_type;

    adcs_state_type state_reg;
    adcs_state_type state_next;

    logic [6:0] period_cycles;
    logic [7:0] ar_idx;
    logic [7:0] rd_byte;
    logic       rd_hit;
    logic       do_write;
    logic       last_period;
    logic       done_event;

    // Prescaler value zero falls back to a fixed 64-cycle period instead of stalling the divider.
    always_comb begin
        if (state_reg.div_value == 5'h00) begin
            period_cycles = DIV_ZERO_CYCLE; // R15
        end else if (double_speed_clocking) begin
            period_cycles = 7'(DOUBLE_MULT * state_reg.div_value); // R10
        end else begin
            period_cycles = 7'(SINGLE_MULT * state_reg.div_value); // R9
        end
    end

    assign ar_idx      = s_axi_araddr[9:2];
    assign do_write    = state_reg.aw_have && state_reg.w_have && !state_reg.bvalid;
    assign last_period = (state_reg.period_cnt == CONV_PERIODS - 4'h1);
    // Named once so that a software clear in the same cycle can see that the set wins.
    assign done_event  = (state_reg.state == CV_BUSY) && state_reg.enable && last_period
                         && (state_reg.div_cnt == period_cycles - 7'h01);

    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (ar_idx)
            IDX_CLOCK_DIVIDER: rd_byte = {3'h0, state_reg.div_value}; // R8
            IDX_CONTROL: rd_byte = {1'b0, state_reg.quiet, state_reg.enable,
                                    state_reg.done_flag, state_reg.start, state_reg.chan};
            IDX_RESULT_LOW:    rd_byte = {6'h00, state_reg.result[1:0]}; // R12
            IDX_RESULT_HIGH:   rd_byte = state_reg.result[9:2]; // R11
            IDX_PIN_ASSIGN:    rd_byte = state_reg.pin_assign;
            IDX_IRQ_STATUS:    rd_byte = {7'h00, state_reg.done_flag};
            IDX_IRQ_ENABLE:    rd_byte = {7'h00, state_reg.irq_en};
            IDX_IRQ_CLEAR:     rd_byte = 8'h00;
            default:           rd_hit  = 1'b0;
        endcase
    end

    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;

        // Write address and data are taken independently, one write at a time.
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.aw_have = 1'b1;
            state_next.w_idx   = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.w_have  = 1'b1;
            state_next.w_data  = s_axi_wdata[7:0];
            state_next.w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // Conversion sequencing runs before the register write so that a software
        // write in the same cycle can still override the fields it owns.
        case (state_reg.state)
            CV_IDLE: begin
                state_next.div_cnt    = 7'h00;
                state_next.period_cnt = 4'h0;
            end
            CV_BUSY: begin
                if (!state_reg.enable) begin
                    state_next.state  = CV_IDLE; // R3
                    state_next.start  = 1'b0;
                    state_next.sample = 1'b0;
                end else if (state_reg.div_cnt == period_cycles - 7'h01) begin
                    state_next.div_cnt    = 7'h00;
                    state_next.tick       = 1'b1;
                    state_next.sample     = 1'b0;
                    state_next.period_cnt = state_reg.period_cnt + 4'h1;
                    if (last_period) begin
                        state_next.state     = CV_IDLE; // R16
                        state_next.start     = 1'b0; // R6
                        state_next.result    = core_result; // R18
                        state_next.done_flag = 1'b1; // R4
                    end
                end else begin
                    state_next.div_cnt = state_reg.div_cnt + 7'h01;
                end
            end
            default: begin
                state_next.state = CV_IDLE;
            end
        endcase

        if (do_write) begin
            state_next.aw_have = 1'b0;
            state_next.w_have  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = RESP_OKAY;
            if (state_reg.w_lane0) begin
                case (state_reg.w_idx)
                    IDX_CLOCK_DIVIDER: begin
                        state_next.div_value = state_reg.w_data[DIV_VALUE_MSB:0]; // R8
                    end
                    IDX_CONTROL: begin
                        state_next.quiet  = state_reg.w_data[CTRL_QUIET_BIT];
                        state_next.enable = state_reg.w_data[CTRL_ENABLE_BIT]; // R3
                        state_next.chan   = state_reg.w_data[CTRL_CHAN_MSB:0]; // R7
                        // A zero clears the flag; a hardware set this cycle wins.
                        if (!state_reg.w_data[CTRL_DONE_BIT] && !done_event) begin
                            state_next.done_flag = 1'b0; // R4
                        end
                        if (state_reg.w_data[CTRL_START_BIT] && state_reg.state == CV_IDLE
                            && state_reg.w_data[CTRL_ENABLE_BIT]
                            && state_reg.pin_assign[state_reg.w_data[CTRL_CHAN_MSB:0]]) begin
                            state_next.state     = CV_BUSY; // R17
                            state_next.start     = 1'b1; // R6
                            state_next.sample    = 1'b1;
                            state_next.chan_conv = state_reg.w_data[CTRL_CHAN_MSB:0]; // R14
                        end
                    end
                    IDX_PIN_ASSIGN: state_next.pin_assign = state_reg.w_data; // R1
                    IDX_IRQ_ENABLE: state_next.irq_en = state_reg.w_data[IRQ_DONE_BIT];
                    IDX_IRQ_CLEAR: begin
                        if (state_reg.w_data[IRQ_DONE_BIT] && !done_event) begin
                            state_next.done_flag = 1'b0; // R4
                        end
                    end
                    IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_IRQ_STATUS: begin
                        state_next.bresp = RESP_OKAY;
                    end
                    default: state_next.bresp = RESP_SLVERR;
                endcase
            end else if (!(state_reg.w_idx inside {IDX_CLOCK_DIVIDER, IDX_CONTROL,
                           IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_PIN_ASSIGN,
                           IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR})) begin
                state_next.bresp = RESP_SLVERR;
            end
        end
        state_next.awready = !state_next.aw_have && !state_next.bvalid;
        state_next.wready  = !state_next.w_have && !state_next.bvalid;

        // Reads answer one cycle after the address is taken.
        if (s_axi_rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state_reg.arready) begin
            state_next.rvalid = 1'b1;
            state_next.rdata  = {24'h000000, rd_byte};
            state_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        state_next.arready = !state_next.rvalid;

        // Checking helpers: cycles since the last tick and ticks in the current conversion.
        if (!state_reg.start) begin
            state_next.gap_cnt    = 8'h00;
            state_next.ticks_seen = 4'h0;
        end else if (state_reg.tick) begin
            state_next.gap_cnt    = 8'h01;
            state_next.ticks_seen = state_reg.ticks_seen + 4'h1;
        end else begin
            state_next.gap_cnt = state_reg.gap_cnt + 8'h01;
        end

        state_next.idle_req = (state_next.state == CV_BUSY) && state_next.quiet; // R2
        state_next.irq      = state_next.done_flag && state_next.irq_en; // R5 R13
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg            <= '0;
            state_reg.state      <= CV_IDLE;
            state_reg.pin_assign <= RST_PIN_ASSIGN;
            state_reg.div_value  <= RST_CLOCK_DIVIDER[DIV_VALUE_MSB:0];
            state_reg.quiet      <= RST_CONTROL[CTRL_QUIET_BIT];
            state_reg.enable     <= RST_CONTROL[CTRL_ENABLE_BIT];
            state_reg.chan       <= RST_CONTROL[CTRL_CHAN_MSB:0];
            state_reg.result     <= RST_RESULT;
            state_reg.awready    <= 1'b1;
            state_reg.wready     <= 1'b1;
            state_reg.arready    <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready        = state_reg.awready;
    assign s_axi_wready         = state_reg.wready;
    assign s_axi_bvalid         = state_reg.bvalid;
    assign s_axi_bresp          = state_reg.bresp;
    assign s_axi_arready        = state_reg.arready;
    assign s_axi_rvalid         = state_reg.rvalid;
    assign s_axi_rdata          = state_reg.rdata;
    assign s_axi_rresp          = state_reg.rresp;
    assign analog_pin_enable    = state_reg.pin_assign; // R1
    assign channel_select       = state_reg.chan_conv;
    assign converter_enable     = state_reg.enable;
    assign sample_hold          = state_reg.sample;
    assign converter_clock_tick = state_reg.tick;
    assign conversion_busy      = state_reg.start;
    assign cpu_idle_request     = state_reg.idle_req;
    assign adc_irq              = state_reg.irq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_pin_route_follow: assert property (do_write && state_reg.w_lane0 // R1
        && state_reg.w_idx == IDX_PIN_ASSIGN |=> analog_pin_enable == $past(state_reg.w_data))
        else $error("pin routing does not follow the pin assign write");
    a_quiet_idle_req: assert property (conversion_busy && state_reg.quiet // R2
        |-> cpu_idle_request)
        else $error("idle request missing during quiet conversion");
    a_standby_abort: assert property (conversion_busy && !converter_enable // R3
        |=> !conversion_busy)
        else $error("conversion kept running in standby");
    a_abort_no_flag: assert property (conversion_busy && !converter_enable // R3
        && !state_reg.done_flag |=> !state_reg.done_flag)
        else $error("standby abort raised the done flag");
    a_done_sets_flag: assert property (done_event |=> state_reg.done_flag // R4
        && !conversion_busy && state_reg.result == $past(core_result))
        else $error("end of conversion did not set flag, clear start and load result");
    a_done_held: assert property (state_reg.done_flag && !do_write // R4
        |=> state_reg.done_flag)
        else $error("done flag cleared without a software write");
    a_irq_source: assert property (adc_irq == (state_reg.done_flag && state_reg.irq_en)) // R5 R13
        else $error("interrupt request does not follow flag and enable");
    a_chan_stable: assert property (conversion_busy && $past(conversion_busy) // R7
        |-> $stable(channel_select))
        else $error("channel changed during a conversion");
    a_tick_period: assert property ((converter_clock_tick && state_reg.ticks_seen != 4'h0) // R9
        |-> state_reg.gap_cnt == {1'b0, period_cycles})
        else $error("converter clock period wrong");
    a_eleven_ticks: assert property ($fell(conversion_busy) && $past(converter_enable) // R16
        |-> ##0 $past(state_reg.ticks_seen) == CONV_PERIODS - 4'h1 && converter_clock_tick)
        else $error("conversion did not last eleven converter periods");
    a_start_refused: assert property (do_write && state_reg.w_idx == IDX_CONTROL // R17
        && !conversion_busy && !state_reg.w_data[CTRL_ENABLE_BIT] |=> !conversion_busy)
        else $error("conversion started in standby");
    a_unassigned_refused: assert property (do_write && state_reg.w_idx == IDX_CONTROL // R17
        && !state_reg.pin_assign[state_reg.w_data[CTRL_CHAN_MSB:0]] && !conversion_busy
        |=> !conversion_busy)
        else $error("conversion started on an unassigned channel");
    a_result_hold: assert property (!done_event |=> $stable(state_reg.result)) // R18
        else $error("result changed outside the end of a conversion");
    a_sample_first: assert property ($rose(conversion_busy) |-> sample_hold ##1 sample_hold) // R16
        else $error("sample and hold not held at conversion start");

endmodule : adcs_sequencer

// ---- verification/adcs_core_model.sv ----
// Purpose: Behavioural converter core facing the sequencer, answering with a tagged result.
// Assumes: The sequencer samples core_result only while conversion_busy is high.
// Notes:   Outside a conversion the output changes every cycle, so a stale sample shows.
`timescale 1ns/1ps
module adcs_core_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic [2:0] channel_select,
    input  wire logic       sample_hold,
    input  wire logic       conversion_busy,
    output logic [9:0]      core_result
);
    logic [2:0] held_chan;
    logic [9:0] last_out;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            held_chan <= 3'h0;
            last_out  <= 10'h000;
        end else begin
            if (sample_hold) begin
                held_chan <= channel_select;
            end
            last_out <= core_result;
        end
    end

    // The input index is woven into the data so that a wrong channel is visible in the result.
    assign core_result = conversion_busy ? {held_chan, 2'b10, held_chan, 2'b01} : ~last_out;
endmodule : adcs_core_model

// ---- verification/adc_sequencer_regs_tb_top.sv ----
// Purpose: Self-checking bench of the converter sequencer over its register bus.
// Assumes: Bus answers come from registered outputs, so values read just after an edge are
//          the ones sampled at that edge.
// Notes:   bready and rready stay high throughout; the slave may answer at any time.
`timescale 1ns/1ps
module adc_sequencer_regs_tb_top import adcs_pkg::*; ;
    logic        clk_sys, rst_b, awvalid, wvalid, bready, arvalid, rready, ds;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        cen, sh, tick, busy, idle_req, adc_irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [3:0]  wstrb;
    logic [9:0]  core_result;
    logic [7:0]  pin_en;
    logic [2:0]  chan;
    int          errors, tests_run, i;
    int          n_busy = 0, n_tick = 0, n_sh = 0, n_idle = 0;
    logic [4:0]  divs [8] = '{5'h01, 5'h01, 5'h00, 5'h03, 5'h02, 5'h05, 5'h01, 5'h1f};

    adcs_sequencer #(.ADDR_W(12)) DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .double_speed_clocking(ds), .core_result(core_result), .analog_pin_enable(pin_en),
        .channel_select(chan), .converter_enable(cen), .sample_hold(sh),
        .converter_clock_tick(tick), .conversion_busy(busy), .cpu_idle_request(idle_req),
        .adc_irq(adc_irq));

    adcs_core_model core (
        .clk_sys(clk_sys), .rst_b(rst_b), .channel_select(chan), .sample_hold(sh),
        .conversion_busy(busy), .core_result(core_result));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        n_busy <= n_busy + int'(busy);
        n_tick <= n_tick + int'(tick);
        n_sh   <= n_sh + int'(sh);
        n_idle <= n_idle + int'(idle_req);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        awaddr  <= {2'b00, idx, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, RESP_OKAY}, "write answer");
    endtask : wr

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] rs);
        araddr  <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk(rdata, {24'h0, exp}, "read data");
        chk({30'h0, rresp}, {30'h0, rs}, "read answer");
    endtask : rchk

    // One full conversion, with a second start while busy that must leave it untouched.
    task automatic conv(input logic [2:0] ch, input logic [4:0] div, input logic dsp,
                        input logic q);
        int         p, b0, t0, s0, i0, t;
        logic [7:0] ctl;
        logic [9:0] res;
        p   = (div == 5'h0) ? 64 : (dsp ? DOUBLE_MULT : SINGLE_MULT) * int'(div);
        ctl = {1'b0, q, 1'b1, 2'b00, ch};
        res = {ch, 2'b10, ch, 2'b01};
        ds <= dsp;
        wr(IDX_CLOCK_DIVIDER, {3'h0, div});
        b0 = n_busy;
        t0 = n_tick;
        s0 = n_sh;
        i0 = n_idle;
        wr(IDX_CONTROL, ctl | 8'h08);
        chk({29'h0, chan}, {29'h0, ch}, "channel");
        wr(IDX_CONTROL, (ctl | 8'h08) ^ 8'h01);
        chk({29'h0, chan}, {29'h0, ch}, "restart");
        rchk(IDX_CONTROL, (ctl | 8'h08) ^ 8'h01, RESP_OKAY);
        for (t = 0; busy !== 1'b0 && t < 3000; t++) @(posedge clk_sys);
        // The counters hold the last edge's sample only one edge later.
        @(posedge clk_sys);
        chk(n_busy - b0, 11 * p, "busy span");
        chk(n_tick - t0, 11, "ticks");
        chk(n_sh - s0, p, "sample span");
        chk(n_idle - i0, q ? 11 * p : 0, "idle span");
        rchk(IDX_RESULT_HIGH, res[9:2], RESP_OKAY);
        rchk(IDX_RESULT_LOW, {6'h0, res[1:0]}, RESP_OKAY);
        rchk(IDX_CONTROL, (ctl ^ 8'h01) | 8'h10, RESP_OKAY);
        chk({31'h0, adc_irq}, 1, "irq");
        wr(IDX_IRQ_ENABLE, 8'h00);
        @(posedge clk_sys);
        chk({31'h0, adc_irq}, 0, "irq masked");
        rchk(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
        wr(IDX_IRQ_ENABLE, 8'h01);
        @(posedge clk_sys);
        chk({31'h0, adc_irq}, 1, "irq unmasked");
        if (ch[0]) wr(IDX_IRQ_CLEAR, 8'h01);
        else wr(IDX_CONTROL, ctl);
        @(posedge clk_sys);
        chk({31'h0, adc_irq}, 0, "irq cleared");
        rchk(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
    endtask : conv

    task automatic conclude();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    initial begin
        {rst_b, awvalid, wvalid, arvalid, ds} = 5'h0;
        {bready, rready} = 2'b11;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        {errors, tests_run} = '0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (i = 0; i < 5; i++) rchk(IDX_CLOCK_DIVIDER + 8'(i), 8'h00, RESP_OKAY);
        rchk(8'h10, 8'h00, RESP_SLVERR);
        wr(IDX_PIN_ASSIGN, 8'ha5);
        rchk(IDX_PIN_ASSIGN, 8'ha5, RESP_OKAY);
        chk({24'h0, pin_en}, 32'ha5, "pins");
        wstrb <= 4'h0;
        wr(IDX_PIN_ASSIGN, 8'h3c);
        wstrb <= 4'hf;
        chk({24'h0, pin_en}, 32'ha5, "masked write");
        wr(IDX_CLOCK_DIVIDER, 8'hff);
        rchk(IDX_CLOCK_DIVIDER, 8'h1f, RESP_OKAY);
        wr(IDX_CONTROL, 8'h80);
        rchk(IDX_CONTROL, 8'h00, RESP_OKAY);
        wr(IDX_RESULT_HIGH, 8'h5a);
        rchk(IDX_RESULT_HIGH, 8'h00, RESP_OKAY);
        wr(IDX_PIN_ASSIGN, 8'hff);
        wr(IDX_CONTROL, 8'h0b);
        chk({30'h0, cen, busy}, 0, "standby start");
        wr(IDX_PIN_ASSIGN, 8'hfd);
        wr(IDX_CONTROL, 8'h29);
        chk({30'h0, cen, busy}, 2, "unassigned start");
        wr(IDX_PIN_ASSIGN, 8'hff);
        wr(IDX_IRQ_ENABLE, 8'h01);
        for (i = 0; i < 8; i++) conv(3'(i), divs[i], i[1], i[0] ^ i[2]);
        conclude();
    end

    initial begin
        #200000;
        errors++;
        conclude();
    end
endmodule : adc_sequencer_regs_tb_top
